/* core/tscr_defines.vh */
`ifndef TSCR_DEFINES_VH
`define TSCR_DEFINES_VH
// *****************************************
// register indexes (byte address = 4*idx)
// *****************************************
`define TSCR_IDX_MODE 10'h000
`define TSCR_IDX_OPCFG 10'h001
`define TSCR_IDX_BUSADDR 10'h002
`define TSCR_IDX_ANACLK 10'h003
`define TSCR_IDX_CHAN 10'h008
`define TSCR_IDX_SCANPAR 10'h019
`define TSCR_IDX_STATUS 10'h01a
// *****************************************
// reset values
// *****************************************
`define TSCR_RST_MODE 8'h01
`define TSCR_RST_OPCFG 8'h09
`define TSCR_RST_BUSADDR 8'h2a
`define TSCR_RST_ANACLK 8'h2b
`define TSCR_RST_CHAN 10'h000
`define TSCR_RST_SCANPAR 5'h00
// fixed bus address when the select pin is low
`define TSCR_FIXED_ADDR 7'h2b
// *****************************************
// mode register bits
// *****************************************
`define TSCR_M_RXREQ 7
`define TSCR_M_TXREQ 6
`define TSCR_M_SCAN 5
`define TSCR_M_STNBY 4
`define TSCR_M_RXDIG 3
`define TSCR_M_TXDIG 2
`define TSCR_M_RDSEN 1
`define TSCR_M_BYPASS 0
// *****************************************
// operation register bits
// *****************************************
`define TSCR_O_SWRST 7
`define TSCR_O_RECAL 6
`define TSCR_O_FMONO 5
`define TSCR_O_TXMONO 4
`define TSCR_O_TC 3
`define TSCR_O_RDSTOG 2
`define TSCR_O_TMO_HI 1
`define TSCR_O_TMO_LO 0
// other field positions
`define TSCR_B_THRMSB 7
`define TSCR_A_BBRST 5
// *****************************************
// resolved modes
// *****************************************
`define TSCR_MODE_IDLE 2'h0
`define TSCR_MODE_RX 2'h1
`define TSCR_MODE_TX 2'h2
`define TSCR_MODE_STBY 2'h3
// *****************************************
// timing: clock rate and idle timeouts
// *****************************************
`define TSCR_CLK_HZ 200000000
`define TSCR_SEC_PER_MIN 16'h003c
`define TSCR_TMO_0_MIN 16'h0001
`define TSCR_TMO_1_MIN 16'h0003
`define TSCR_TMO_2_MIN 16'h0005
`define TSCR_TMO_NEVER 2'h3
`define TSCR_TMO_SEL0 2'h0
`define TSCR_TMO_SEL1 2'h1
`define TSCR_SYNC_SETTLE 2'h3
`endif

/* core/tscr_regs.v */
// Function
// [RULE1] rx audio digital when bit set
// [RULE2] tx audio digital when bit set
// [RULE3] bypass picks programmed channel, else scan
// [RULE4] rx beats tx beats standby
// [RULE5] soft reset restores all defaults
// [RULE6] recal holds fsm reset, reruns calibration
// [RULE7] force rx mono when bit set
// [RULE8] tx mono when bit set
// [RULE9] emphasis 75us when set, 50us clear
// [RULE10] group send after current group, rds on
// [RULE11] idle timeout 1,3,5 minutes or never
// [RULE12] bus address bit7 is threshold msb
// [RULE13] bus address fixed or programmed by pin
// [RULE14] scan start clears when scan finishes
// [RULE15] group send toggle detected as change
// [RULE16] written bits read back as written
`timescale 1ns/1ps
`include "tscr_defines.vh"

module tscr_regs #(
  parameter CYC_PER_SEC = `TSCR_CLK_HZ
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire addr_select_input,
  input wire [9:0] scan_channel,
  input wire scan_done,
  input wire rds_group_done,
  output reg [1:0] mode,
  output reg scan_start,
  output reg rx_digital_audio_sel,
  output reg tx_digital_audio_sel,
  output reg rds_enable,
  output reg [9:0] channel_index,
  output reg fsm_reset,
  output reg calib_start,
  output reg force_rx_mono,
  output reg tx_mono_select,
  output reg emphasis_time_const,
  output reg rds_fetch,
  output reg [5:0] scan_threshold,
  output reg [6:0] bus_address,
  output reg baseband_reset_n
);

  // ****************************************
  // address decode
  // ****************************************
  // true when a word index holds a register
  function tscr_mapped;
    input [9:0] idx;
    begin
      if (idx == `TSCR_IDX_MODE) begin
        tscr_mapped = 1'b1;
      end else if (idx == `TSCR_IDX_OPCFG) begin
        tscr_mapped = 1'b1;
      end else if (idx == `TSCR_IDX_BUSADDR) begin
        tscr_mapped = 1'b1;
      end else if (idx == `TSCR_IDX_ANACLK) begin
        tscr_mapped = 1'b1;
      end else if (idx == `TSCR_IDX_CHAN) begin
        tscr_mapped = 1'b1;
      end else if (idx == `TSCR_IDX_SCANPAR) begin
        tscr_mapped = 1'b1;
      end else if (idx == `TSCR_IDX_STATUS) begin
        tscr_mapped = 1'b1;
      end else begin
        tscr_mapped = 1'b0;
      end
    end
  endfunction

  localparam [31:0] CYC_SEC = CYC_PER_SEC;
  localparam [15:0] SEC_T0 = `TSCR_TMO_0_MIN * `TSCR_SEC_PER_MIN;
  localparam [15:0] SEC_T1 = `TSCR_TMO_1_MIN * `TSCR_SEC_PER_MIN;
  localparam [15:0] SEC_T2 = `TSCR_TMO_2_MIN * `TSCR_SEC_PER_MIN;

  wire [9:0] idx = paddr[11:2];
  wire setup = psel & ~penable;
  // writes land only at the completing access edge
  wire wr_en = psel & penable & pwrite & pready;

  reg [7:0] mode_r;
  reg [7:0] opcfg_r;
  reg [7:0] busaddr_r;
  reg [7:0] anaclk_r;
  reg [9:0] chan_r;
  reg [4:0] scanpar_r;
  reg [7:0] mode_nxt;
  reg [7:0] opcfg_nxt;
  reg [7:0] busaddr_nxt;
  reg [7:0] anaclk_nxt;
  reg [9:0] chan_nxt;
  reg [4:0] scanpar_nxt;
  reg [2:0] sync_r;
  reg sel_latched_r;
  reg [1:0] settle_r;
  reg rds_prev_r;
  reg rds_pend_r;
  reg recal_prev_r;
  reg [31:0] cyc_r;
  reg [15:0] sec_r;
  reg tmo_hit_r;
  reg [1:0] mode_res;
  reg [15:0] sec_lim;
  reg [31:0] rd_val;

  // ****************************************
  // register next values
  // ****************************************
  // self updates first, then write data, then soft reset
  always @* begin
    mode_nxt = mode_r;
    opcfg_nxt = opcfg_r;
    busaddr_nxt = busaddr_r;
    anaclk_nxt = anaclk_r;
    chan_nxt = chan_r;
    scanpar_nxt = scanpar_r;
    // [RULE14] scan start self clear
    if (scan_done) begin
      mode_nxt[`TSCR_M_SCAN] = 1'b0;
    end
    // [RULE16] plain read back storage
    if (wr_en) begin
      if (idx == `TSCR_IDX_MODE) begin
        mode_nxt = pwdata[7:0];
      end else if (idx == `TSCR_IDX_OPCFG) begin
        opcfg_nxt = pwdata[7:0];
      end else if (idx == `TSCR_IDX_BUSADDR) begin
        busaddr_nxt = pwdata[7:0];
      end else if (idx == `TSCR_IDX_ANACLK) begin
        anaclk_nxt = pwdata[7:0];
      end else if (idx == `TSCR_IDX_CHAN) begin
        chan_nxt = pwdata[9:0];
      end else if (idx == `TSCR_IDX_SCANPAR) begin
        scanpar_nxt = pwdata[4:0];
      end
    end
    // [RULE5] soft reset to defaults
    if (wr_en && idx == `TSCR_IDX_OPCFG &&
        pwdata[`TSCR_O_SWRST]) begin
      mode_nxt = `TSCR_RST_MODE;
      opcfg_nxt = `TSCR_RST_OPCFG;
      busaddr_nxt = `TSCR_RST_BUSADDR;
      anaclk_nxt = `TSCR_RST_ANACLK;
      chan_nxt = `TSCR_RST_CHAN;
      scanpar_nxt = `TSCR_RST_SCANPAR;
    end
  end

  // register storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `TSCR_RST_MODE;
      opcfg_r <= `TSCR_RST_OPCFG;
      busaddr_r <= `TSCR_RST_BUSADDR;
      anaclk_r <= `TSCR_RST_ANACLK;
      chan_r <= `TSCR_RST_CHAN;
      scanpar_r <= `TSCR_RST_SCANPAR;
    end else begin
      mode_r <= mode_nxt;
      opcfg_r <= opcfg_nxt;
      busaddr_r <= busaddr_nxt;
      anaclk_r <= anaclk_nxt;
      chan_r <= chan_nxt;
      scanpar_r <= scanpar_nxt;
    end
  end

  // ****************************************
  // apb read path
  // ****************************************
  // read mux; status word shows resolved state
  always @* begin
    rd_val = 32'h0000_0000;
    if (idx == `TSCR_IDX_MODE) begin
      rd_val[7:0] = mode_r;
    end else if (idx == `TSCR_IDX_OPCFG) begin
      rd_val[7:0] = opcfg_r;
    end else if (idx == `TSCR_IDX_BUSADDR) begin
      rd_val[7:0] = busaddr_r;
    end else if (idx == `TSCR_IDX_ANACLK) begin
      rd_val[7:0] = anaclk_r;
    end else if (idx == `TSCR_IDX_CHAN) begin
      rd_val[9:0] = chan_r;
    end else if (idx == `TSCR_IDX_SCANPAR) begin
      rd_val[4:0] = scanpar_r;
    end else if (idx == `TSCR_IDX_STATUS) begin
      rd_val[1:0] = mode;
      rd_val[2] = rds_pend_r;
      rd_val[3] = sel_latched_r;
      rd_val[4] = tmo_hit_r;
    end
  end

  // one wait-free access: data prepared in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~tscr_mapped(idx);
      if (setup && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // ****************************************
  // address select pin
  // ****************************************
  // three stage sync; second and third must agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 3'h0;
      settle_r <= 2'h0;
      sel_latched_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], addr_select_input};
      // [RULE13] strap followed whenever the last two stages agree, once settled
      if (settle_r != `TSCR_SYNC_SETTLE) begin
        settle_r <= settle_r + 2'h1;
      end else if (sync_r[2] == sync_r[1]) begin
        sel_latched_r <= sync_r[2];
        settle_r <= settle_r;
      end
    end
  end

  // ****************************************
  // idle to standby timer
  // ****************************************
  // [RULE11] timeout choice in seconds
  always @* begin
    if (opcfg_r[`TSCR_O_TMO_HI:`TSCR_O_TMO_LO] ==
        `TSCR_TMO_SEL0) begin
      sec_lim = SEC_T0;
    end else if (opcfg_r[`TSCR_O_TMO_HI:`TSCR_O_TMO_LO] ==
        `TSCR_TMO_SEL1) begin
      sec_lim = SEC_T1;
    end else begin
      sec_lim = SEC_T2;
    end
  end

  // counts while neither rx nor tx is requested and fsm_reset is low; never when disabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 32'h0000_0000;
      sec_r <= 16'h0000;
      tmo_hit_r <= 1'b0;
    end else if (mode_r[`TSCR_M_RXREQ] ||
        mode_r[`TSCR_M_TXREQ] || fsm_reset ||
        opcfg_r[`TSCR_O_TMO_HI:`TSCR_O_TMO_LO] ==
        `TSCR_TMO_NEVER) begin
      cyc_r <= 32'h0000_0000;
      sec_r <= 16'h0000;
      tmo_hit_r <= 1'b0;
    end else if (!tmo_hit_r) begin
      if (cyc_r == CYC_SEC - 32'h0000_0001) begin
        cyc_r <= 32'h0000_0000;
        sec_r <= sec_r + 16'h0001;
        // [RULE11] expiry after chosen minutes
        tmo_hit_r <= (sec_r + 16'h0001) >= sec_lim;
      end else begin
        cyc_r <= cyc_r + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // mode resolution
  // ****************************************
  // [RULE4] rx over tx over standby
  always @* begin
    if (mode_r[`TSCR_M_RXREQ]) begin
      mode_res = `TSCR_MODE_RX;
    end else if (mode_r[`TSCR_M_TXREQ]) begin
      mode_res = `TSCR_MODE_TX;
    end else if (mode_r[`TSCR_M_STNBY] || tmo_hit_r) begin
      mode_res = `TSCR_MODE_STBY;
    end else begin
      mode_res = `TSCR_MODE_IDLE;
    end
  end

  // ****************************************
  // rds group send
  // ****************************************
  // a new toggle during a fetch stays pending
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rds_prev_r <= 1'b0;
      rds_pend_r <= 1'b0;
      rds_fetch <= 1'b0;
    end else begin
      rds_prev_r <= opcfg_r[`TSCR_O_RDSTOG];
      if (!mode_r[`TSCR_M_RDSEN]) begin
        // [RULE10] rds inactive drops requests
        rds_pend_r <= 1'b0;
        rds_fetch <= 1'b0;
      end else begin
        // [RULE15] any change is one request
        rds_pend_r <= (rds_pend_r & ~rds_group_done) |
          (opcfg_r[`TSCR_O_RDSTOG] ^ rds_prev_r);
        // [RULE10] fetch after current group
        rds_fetch <= rds_pend_r & rds_group_done;
      end
    end
  end

  // ****************************************
  // control outputs
  // ****************************************
  // all outputs registered, from the bank, the strap latch, the timer or scan_channel
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `TSCR_MODE_IDLE;
      scan_start <= 1'b0;
      rx_digital_audio_sel <= 1'b0;
      tx_digital_audio_sel <= 1'b0;
      rds_enable <= 1'b0;
      channel_index <= `TSCR_RST_CHAN;
      fsm_reset <= 1'b0;
      recal_prev_r <= 1'b0;
      calib_start <= 1'b0;
      force_rx_mono <= 1'b0;
      tx_mono_select <= 1'b0;
      emphasis_time_const <= 1'b1;
      scan_threshold <= 6'h00;
      bus_address <= `TSCR_FIXED_ADDR;
      baseband_reset_n <= 1'b1;
    end else begin
      mode <= mode_res;
      scan_start <= mode_r[`TSCR_M_SCAN];
      // [RULE1] rx audio route
      rx_digital_audio_sel <= mode_r[`TSCR_M_RXDIG];
      // [RULE2] tx audio source
      tx_digital_audio_sel <= mode_r[`TSCR_M_TXDIG];
      rds_enable <= mode_r[`TSCR_M_RDSEN];
      // [RULE3] channel source select
      channel_index <= mode_r[`TSCR_M_BYPASS] ?
        chan_r : scan_channel;
      // [RULE6] fsm held while recal set
      fsm_reset <= opcfg_r[`TSCR_O_RECAL];
      recal_prev_r <= opcfg_r[`TSCR_O_RECAL];
      // [RULE6] rerun power up on release
      calib_start <= recal_prev_r & ~opcfg_r[`TSCR_O_RECAL];
      // [RULE7] forced rx mono
      force_rx_mono <= opcfg_r[`TSCR_O_FMONO];
      // [RULE8] tx stereo or mono
      tx_mono_select <= opcfg_r[`TSCR_O_TXMONO];
      // [RULE9] emphasis 50 or 75 us
      emphasis_time_const <= opcfg_r[`TSCR_O_TC];
      // [RULE12] threshold msb from bus addr
      scan_threshold <= {busaddr_r[`TSCR_B_THRMSB], scanpar_r};
      // [RULE13] fixed or programmed address
      bus_address <= sel_latched_r ? busaddr_r[6:0] :
        `TSCR_FIXED_ADDR;
      baseband_reset_n <= anaclk_r[`TSCR_A_BBRST];
    end
  end

endmodule

/* bench/tscr_regs_sva.sv */
`timescale 1ns/1ps
// ************************************
// register bank port checks
// ************************************
module tscr_regs_sva #(
  parameter CYC_PER_SEC = 200000000
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire addr_select_input,
  input wire scan_done,
  input wire rds_group_done,
  input wire [1:0] mode,
  input wire scan_start,
  input wire rx_digital_audio_sel,
  input wire fsm_reset,
  input wire calib_start,
  input wire emphasis_time_const,
  input wire rds_fetch,
  input wire [5:0] scan_threshold,
  input wire [6:0] bus_address
);
  // a write lands at the access edge; outputs follow one clock later
  wire acc = psel && penable && pwrite && pready;
  wire w_mode = acc && paddr[11:2] == 10'h000;
  wire w_op = acc && paddr[11:2] == 10'h001;
  wire w_ba = acc && paddr[11:2] == 10'h002;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rxdig;
    w_mode |-> ##2 rx_digital_audio_sel == $past(pwdata[3], 2);
  endproperty
  a_rxdig: assert property (p_rxdig) else $error("rx audio select");
  property p_rxwin;
    w_mode && pwdata[7] |-> ##2 mode == 2'h1;
  endproperty
  a_rxwin: assert property (p_rxwin) else $error("rx not chosen");
  property p_txwin;
    w_mode && pwdata[7:6] == 2'b01 |-> ##2 mode == 2'h2;
  endproperty
  a_txwin: assert property (p_txwin) else $error("tx not chosen");
  property p_swrst;
    w_op && pwdata[7] |-> ##2 emphasis_time_const && !fsm_reset;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset");
  property p_recal;
    w_op && !pwdata[7] |-> ##2 fsm_reset == $past(pwdata[6], 2);
  endproperty
  a_recal: assert property (p_recal) else $error("fsm hold");
  // the restart must be a single pulse, not a level
  property p_calib;
    $fell(fsm_reset) |-> ##[0:1] calib_start ##1 !calib_start;
  endproperty
  a_calib: assert property (p_calib) else $error("calibration");
  property p_tc;
    w_op && !pwdata[7] |-> ##2 emphasis_time_const == $past(pwdata[3], 2);
  endproperty
  a_tc: assert property (p_tc) else $error("emphasis");
  property p_fetch;
    rds_fetch |-> $past(rds_group_done) ##1 !rds_fetch;
  endproperty
  a_fetch: assert property (p_fetch) else $error("rds fetch");
  property p_thr;
    w_ba |-> ##2 scan_threshold[5] == $past(pwdata[7], 2);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold msb");
  // the strap passes a synchroniser, so allow it a few clocks
  property p_fixaddr;
    !addr_select_input [*8] |-> ##2 bus_address == 7'h2b;
  endproperty
  a_fixaddr: assert property (p_fixaddr) else $error("fixed addr");
  property p_scan;
    scan_done && !acc |-> ##2 !scan_start;
  endproperty
  a_scan: assert property (p_scan) else $error("scan start kept");
  c_scan: cover property (scan_done);
  c_fetch: cover property (rds_fetch);
  c_calib: cover property (calib_start);
endmodule

bind tscr_regs tscr_regs_sva #(.CYC_PER_SEC(CYC_PER_SEC)) i_tscr_regs_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .addr_select_input(addr_select_input), .scan_done(scan_done),
  .rds_group_done(rds_group_done), .mode(mode), .scan_start(scan_start),
  .rx_digital_audio_sel(rx_digital_audio_sel), .fsm_reset(fsm_reset),
  .calib_start(calib_start), .emphasis_time_const(emphasis_time_const),
  .rds_fetch(rds_fetch), .scan_threshold(scan_threshold),
  .bus_address(bus_address)
);

/* bench/tscr_far_model.sv */
`timescale 1ns/1ps
// ************************************
// scan engine and rds framer stand-in
// ************************************
module tscr_far_model #(
  parameter [9:0] CHAN = 10'h000,
  parameter [7:0] DLY = 8'h14
) (
  input wire pclk,
  input wire presetn,
  input wire scan_start,
  output reg [9:0] scan_channel,
  output reg scan_done,
  output reg rds_group_done
);
  reg prev_r;
  reg [7:0] cnt_r;
  reg [3:0] grp_r;
  // scan runs from the rising request; the result shows only at the end,
  // until the first scan ends the inverse is shown so a stale value cannot pass
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
      cnt_r <= 8'h00;
      grp_r <= 4'h0;
      scan_done <= 1'b0;
      rds_group_done <= 1'b0;
      scan_channel <= ~CHAN;
    end else begin
      prev_r <= scan_start;
      scan_done <= (cnt_r == 8'h01);
      if (cnt_r == 8'h01)
        scan_channel <= CHAN;
      if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
      else if (scan_start && !prev_r)
        cnt_r <= DLY;
      grp_r <= grp_r + 4'h1;
      rds_group_done <= (grp_r == 4'hf);
    end
  end
endmodule

/* bench/transceiver_system_control_regs_bench.sv */
`timescale 1ns/1ps
module transceiver_system_control_regs_bench;
  localparam [9:0] SCH = 10'h2a3;
  localparam [31:0] RV = 32'h2b2a_0901;
  localparam [31:0] PRI = 32'hd050_1000;
  localparam [7:0] PEXP = 8'h6c;
  // short seconds so that every idle timeout code fits in one run
  localparam integer CPS = 2;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg addr_select_input = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg er;
  integer n_fail = 0, n_compared = 0, k, j;
  wire [31:0] prdata;
  wire [9:0] scan_channel, channel_index;
  wire [1:0] mode;
  wire [5:0] scan_threshold;
  wire [6:0] bus_address;
  wire pready, pslverr, scan_done, rds_group_done, scan_start, rx_dig;
  wire tx_dig, rds_en, fsm_reset, calib_start, frm, txm, tc, rds_fetch;
  wire bb_n;
  tscr_regs #(.CYC_PER_SEC(CPS)) i_tscr_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .addr_select_input(addr_select_input), .scan_channel(scan_channel),
    .scan_done(scan_done), .rds_group_done(rds_group_done), .mode(mode),
    .scan_start(scan_start), .rx_digital_audio_sel(rx_dig),
    .tx_digital_audio_sel(tx_dig), .rds_enable(rds_en),
    .channel_index(channel_index), .fsm_reset(fsm_reset),
    .calib_start(calib_start), .force_rx_mono(frm), .tx_mono_select(txm),
    .emphasis_time_const(tc), .rds_fetch(rds_fetch),
    .scan_threshold(scan_threshold), .bus_address(bus_address),
    .baseband_reset_n(bb_n)
  );
  tscr_far_model #(.CHAN(SCH)) i_tscr_far_model (
    .pclk(pclk), .presetn(presetn), .scan_start(scan_start),
    .scan_channel(scan_channel), .scan_done(scan_done),
    .rds_group_done(rds_group_done)
  );
  // ************************************
  // clock, tasks and watchdog
  // ************************************
  initial forever #2.5 pclk = ~pclk;
  task stop_test;
    begin
      $display("n_fail=%0d n_compared=%0d", n_fail, n_compared);
      if (n_fail == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // one apb transfer; the request holds until pready is seen high
  task bus(input w, input [9:0] i, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task rdchk(input [9:0] i, input [31:0] e);
    begin
      bus(0, i, 0);
      chk(rd, e);
    end
  endtask
  task settle;
    repeat (2) @(negedge pclk);
  endtask
  task nofetch;
    begin
      k = 0;
      repeat (60) begin
        @(negedge pclk);
        if (rds_fetch === 1'b1) k = k + 1;
      end
    end
  endtask
  task waitfetch;
    begin
      k = 0;
      while (rds_fetch !== 1'b1 && k < 60) begin
        @(negedge pclk);
        k = k + 1;
      end
    end
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail = n_fail + 1;
    stop_test;
  end
  // ************************************
  // test sequence
  // ************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    for (j = 0; j < 4; j = j + 1) rdchk(j, RV[8*j +: 8]);
    chk(bus_address, 7'h2b);
    chk(tc, 1);
    chk(tx_dig, 0);
    bus(1, 10'h3f, 32'hff);
    chk(er, 1);
    for (j = 0; j < 4; j = j + 1) begin
      bus(1, 0, PRI[31-8*j -: 8] | 32'h1);
      settle;
      chk(mode, PEXP[7-2*j -: 2]);
      rdchk(0, PRI[31-8*j -: 8] | 32'h1);
    end
    for (j = 0; j < 4; j = j + 1) begin
      bus(1, 0, {j[1:0], 2'b01});
      settle;
      chk(rx_dig, j[1]);
      chk(tx_dig, j[0]);
    end
    for (j = 0; j < 2; j = j + 1) begin
      bus(1, 1, j ? 32'h00 : 32'h39);
      settle;
      chk({frm, txm, tc}, j ? 3'b000 : 3'b111);
    end
    // timeout codes 0..2 give 1, 3 and 5 minutes of CPS-cycle seconds
    for (j = 0; j < 3; j = j + 1) begin
      bus(1, 1, j);
      bus(1, 0, 32'h81);
      bus(1, 0, 32'h01);
      k = CPS * 60 * (2 * j + 1);
      repeat (k - 10) @(negedge pclk);
      chk(mode, 0);
      repeat (20) @(negedge pclk);
      chk(mode, 3);
    end
    rdchk(10'h1a, 32'h13);
    bus(1, 1, 32'h0b);
    bus(1, 0, 32'h81);
    bus(1, 0, 32'h01);
    repeat (700) @(negedge pclk);
    chk(mode, 0);
    bus(1, 1, 32'h4b);
    settle;
    chk(fsm_reset, 1);
    bus(1, 1, 32'h0b);
    k = 0;
    while (calib_start !== 1'b1 && k < 20) begin
      @(negedge pclk);
      k = k + 1;
    end
    chk(calib_start, 1);
    bus(1, 8, 32'h155);
    settle;
    chk(channel_index, 10'h155);
    bus(1, 0, 32'h20);
    k = 0;
    while (scan_done !== 1'b1 && k < 60) begin
      @(negedge pclk);
      k = k + 1;
    end
    settle;
    chk(channel_index, SCH);
    rdchk(0, 0);
    bus(1, 0, 32'h03);
    bus(1, 1, 32'h0f);
    chk(rds_en, 1);
    waitfetch;
    chk(rds_fetch, 1);
    nofetch;
    chk(k, 0);
    bus(1, 1, 32'h0b);
    waitfetch;
    chk(rds_fetch, 1);
    bus(1, 0, 32'h01);
    bus(1, 1, 32'h0f);
    chk(rds_en, 0);
    nofetch;
    chk(k, 0);
    @(posedge pclk);
    addr_select_input <= 1;
    bus(1, 2, 32'h95);
    bus(1, 25, 32'h15);
    repeat (12) @(negedge pclk);
    chk(scan_threshold, 6'h35);
    chk(bus_address, 7'h15);
    bus(1, 3, 32'h00);
    settle;
    chk(bb_n, 0);
    bus(1, 1, 32'h80);
    settle;
    for (j = 0; j < 4; j = j + 1) rdchk(j, RV[8*j +: 8]);
    rdchk(25, 0);
    chk(bb_n, 1);
    chk(bus_address, 7'h2a);
    stop_test;
  end
endmodule
